// ### src/cdz_pkg.sv
// clock divisor and doze control: shared constants
// assumes a plain register port and one 250 MHz system clock
package cdz_pkg;
  // ==========================================================
  // register map
  localparam logic [3:0] CDZ_ADDR_CTRL = 4'h0;
  localparam logic [3:0] CDZ_ADDR_STATUS = 4'h2;
  // ==========================================================
  // field positions
  localparam int CDZ_RECOVER_POS = 15;
  localparam int CDZ_DOZE_LSB = 12;
  localparam int CDZ_DOZE_EN_POS = 11;
  localparam int CDZ_RCPOST_LSB = 8;
  localparam int CDZ_POST_LSB = 6;
  localparam int CDZ_PRE_LSB = 0;
  // ==========================================================
  // reset value and special field codes
  localparam logic [15:0] CDZ_CTRL_RST = 16'h3040;
  localparam logic [2:0] CDZ_DOZE_ONE = 3'h0;
  localparam logic [1:0] CDZ_POST_RSVD = 2'h2;
  localparam logic [2:0] CDZ_RCPOST_MAX = 3'h7;
  localparam logic [7:0] CDZ_RCPOST_MAX_TERM = 8'hFF;
endpackage : cdz_pkg

// ### src/cdz_div_enable.sv
// one-cycle enable divider for a power-of-two ratio
// assumes ratio minus one is given as a mask
`timescale 1ns/1ps
module cdz_div_enable
  import cdz_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] terminal,
  output logic tick
);
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  always_comb
  begin
    // wrap on terminal; a smaller new ratio also wraps at once
    if (cnt_r >= terminal)
      cnt_nxt = 8'h00;
    else
      cnt_nxt = cnt_r + 8'h01;
  end
  always_ff @(posedge clk)
  begin
    if (rst)
      cnt_r <= 8'h00;
    else
      cnt_r <= cnt_nxt;
  end
  assign tick = (cnt_r >= terminal);
endmodule : cdz_div_enable

// ### src/cdz_clock_divisor.sv
// clock divisor control register with doze enable generation
// assumes irq_event is a one-cycle pulse from the interrupt logic
//
// Implementation choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module cdz_clock_divisor
  import cdz_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire logic irq_event,
  output logic cpu_tick,
  output logic rc_tick,
  output logic [1:0] pll_output_divider,
  output logic [4:0] pll_input_prescaler,
  output logic doze_active
);
  // ==========================================================
  // register fields
  logic recover_on_interrupt_r, recover_on_interrupt_nxt;
  logic [2:0] doze_ratio_r, doze_ratio_nxt;
  logic doze_enable_r, doze_enable_nxt;
  logic [2:0] fast_rc_postscaler_r, fast_rc_postscaler_nxt;
  logic [1:0] post_r, post_nxt;
  logic [4:0] pre_r, pre_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic cpu_tick_r, rc_tick_r;
  logic wr_div;
  logic [15:0] reg_val;
  logic [7:0] cpu_term, rc_term;
  logic cpu_t, rc_t;

  assign wr_div = wr && (addr == CDZ_ADDR_CTRL);
  assign reg_val = {recover_on_interrupt_r, doze_ratio_r, doze_enable_r,
                    fast_rc_postscaler_r, post_r, 1'b0, pre_r};

  always_comb
  begin
    recover_on_interrupt_nxt = recover_on_interrupt_r;
    doze_ratio_nxt = doze_ratio_r;
    doze_enable_nxt = doze_enable_r;
    fast_rc_postscaler_nxt = fast_rc_postscaler_r;
    post_nxt = post_r;
    pre_nxt = pre_r;
    if (wr_div)
    begin
      recover_on_interrupt_nxt = wdata[CDZ_RECOVER_POS];
      if (!doze_enable_r)
        doze_ratio_nxt = wdata[CDZ_DOZE_LSB +: 3];
      // checked against the ratio held now, not the one being written
      if (doze_ratio_r == CDZ_DOZE_ONE && !doze_enable_r)
        doze_enable_nxt = 1'b0;
      else
        doze_enable_nxt = wdata[CDZ_DOZE_EN_POS];
      fast_rc_postscaler_nxt = wdata[CDZ_RCPOST_LSB +: 3];
      // reserved code is stored but never reaches the pll
      post_nxt = wdata[CDZ_POST_LSB +: 2];
      pre_nxt = wdata[CDZ_PRE_LSB +: 5];
    end
    // the interrupt wins over a same-cycle software set
    if (irq_event && recover_on_interrupt_r)
      doze_enable_nxt = 1'b0;
  end

  // ==========================================================
  // only power-on reset reaches this register
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      recover_on_interrupt_r <= CDZ_CTRL_RST[CDZ_RECOVER_POS];
      doze_ratio_r <= CDZ_CTRL_RST[CDZ_DOZE_LSB +: 3];
      doze_enable_r <= CDZ_CTRL_RST[CDZ_DOZE_EN_POS];
      fast_rc_postscaler_r <= CDZ_CTRL_RST[CDZ_RCPOST_LSB +: 3];
      post_r <= CDZ_CTRL_RST[CDZ_POST_LSB +: 2];
      pre_r <= CDZ_CTRL_RST[CDZ_PRE_LSB +: 5];
    end
    else
    begin
      recover_on_interrupt_r <= recover_on_interrupt_nxt;
      doze_ratio_r <= doze_ratio_nxt;
      doze_enable_r <= doze_enable_nxt;
      fast_rc_postscaler_r <= fast_rc_postscaler_nxt;
      post_r <= post_nxt;
      pre_r <= pre_nxt;
    end
  end

  // ==========================================================
  // read port
  always_comb
  begin
    rdata_nxt = 16'h0000;
    if (rd && addr == CDZ_ADDR_CTRL)
      rdata_nxt = reg_val;
    else if (rd && addr == CDZ_ADDR_STATUS)
      rdata_nxt = {15'h0000, doze_enable_r};
  end
  always_ff @(posedge clk)
  begin
    if (rst)
      rdata_r <= 16'h0000;
    else
      rdata_r <= rdata_nxt;
  end

  // ==========================================================
  // dividers: ratio 2^n, so terminal is a mask of n ones, except rc code 7, which uses eight ones (ratio 256)
  always_comb
  begin
    if (doze_enable_r)
      cpu_term = 8'(({1'b0, 8'h01} << doze_ratio_r) - 9'h001);
    else
      cpu_term = 8'h00;
    if (fast_rc_postscaler_r == CDZ_RCPOST_MAX)
      rc_term = CDZ_RCPOST_MAX_TERM;
    else
      rc_term = 8'(({1'b0, 8'h01} << fast_rc_postscaler_r) - 9'h001);
  end

  cdz_div_enable u_cpu_div (
    .clk(clk),
    .rst(rst),
    .terminal(cpu_term),
    .tick(cpu_t)
  );
  cdz_div_enable u_rc_div (
    .clk(clk),
    .rst(rst),
    .terminal(rc_term),
    .tick(rc_t)
  );

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cpu_tick_r <= 1'b0;
      rc_tick_r <= 1'b0;
      pll_output_divider <= CDZ_CTRL_RST[CDZ_POST_LSB +: 2];
      pll_input_prescaler <= 5'h00;
      doze_active <= 1'b0;
    end
    else
    begin
      cpu_tick_r <= cpu_t;
      rc_tick_r <= rc_t;
      // hold the last legal setting if software writes the reserved code
      if (post_r != CDZ_POST_RSVD)
        pll_output_divider <= post_r;
      pll_input_prescaler <= pre_r;
      doze_active <= doze_enable_r;
    end
  end
  assign cpu_tick = cpu_tick_r;
  assign rc_tick = rc_tick_r;
  assign rdata = rdata_r;
endmodule : cdz_clock_divisor

// ### tb/cdz_clock_divisor_chk.sv
// port checker for the clock divisor register
// assumes one clock and a synchronous high reset
`timescale 1ns/1ps
module cdz_chk
  import cdz_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] rdata,
  input wire logic irq_event,
  input wire logic cpu_tick,
  input wire logic [1:0] pll_output_divider,
  input wire logic [4:0] pll_input_prescaler,
  input wire logic doze_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic wr0;
  logic recover_r;
  assign wr0 = wr && addr == CDZ_ADDR_CTRL;
  // =====
  // shadow of the recovery bit, lags the write by one edge as the
  // design does
  always_ff @(posedge clk)
  begin
    if (rst)
      recover_r <= 1'b0;
    else if (wr0)
      recover_r <= wdata[15];
  end
  AST_RECOVER: assert property
    (irq_event && recover_r |-> ##2 !doze_active) else $error("doze kept");
  AST_NO_RECOVER: assert property
    (irq_event && !recover_r && doze_active && !wr0 && !$past(wr0)
    |-> ##2 doze_active) else $error("doze lost");
  AST_FULL_RATE: assert property
    (!doze_active [*3] |-> cpu_tick) else $error("tick missing");
  // a legal clear of doze lets the next tick follow at once
  AST_DOZE_SLOW: assert property
    (doze_active [*2] ##0 cpu_tick |=> !cpu_tick || !doze_active)
    else $error("fast doze");
  AST_BIT5: assert property
    (!rdata[5]) else $error("bit five set");
  AST_RSVD: assert property
    (pll_output_divider != CDZ_POST_RSVD) else $error("reserved code");
  AST_POST: assert property
    (wr0 && wdata[7:6] != CDZ_POST_RSVD |-> ##2
    pll_output_divider == $past(wdata[7:6], 2)) else $error("post");
  AST_PRE: assert property
    (wr0 |-> ##2 pll_input_prescaler == $past(wdata[4:0], 2))
    else $error("prescaler");
  cover property (irq_event && recover_r);
  cover property (doze_active && cpu_tick);
  cover property (wr0 ##1 rd);
endmodule : cdz_chk
bind cdz_clock_divisor cdz_chk u_chk (.*);

// ### tb/cdz_clock_divisor_test.sv
// register-level bench for the clock divisor block
// assumes the checker is bound in beside it
`timescale 1ns/1ps
module cdz_clock_divisor_test
  import cdz_pkg::*;
;
  logic clk = 0, rst = 1, wr = 0, rd = 0, irq_event = 0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000, rdata;
  logic cpu_tick, rc_tick, doze_active;
  logic [1:0] pll_output_divider;
  logic [4:0] pll_input_prescaler;
  int mismatches = 0, n_tests = 0, cyc = 0, nc, nf;
  cdz_clock_divisor u_dut (
    .clk(clk),
    .rst(rst),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .rd(rd),
    .rdata(rdata),
    .irq_event(irq_event),
    .cpu_tick(cpu_tick),
    .rc_tick(rc_tick),
    .pll_output_divider(pll_output_divider),
    .pll_input_prescaler(pll_input_prescaler),
    .doze_active(doze_active)
  );
  // =====
  initial forever #2 clk = ~clk;
  always @(posedge clk)
    if (++cyc == 4000)
    begin
      mismatches++;
      end_of_test();
    end
  task automatic chk(string s, logic [15:0] e, logic [15:0] g);
    n_tests++;
    if (g !== e)
    begin
      mismatches++;
      $display("FAIL %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task automatic wr_t(logic [3:0] a, logic [15:0] d);
    @(posedge clk);
    wr <= 1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 0;
  endtask : wr_t
  // rdata stands only in the cycle after the strobe
  task automatic rd_t(logic [3:0] a, logic [15:0] e);
    @(posedge clk);
    rd <= 1;
    addr <= a;
    @(posedge clk);
    rd <= 0;
    @(negedge clk);
    chk("rdata", e, rdata);
  endtask : rd_t
  task automatic irq_t();
    @(posedge clk);
    irq_event <= 1;
    @(posedge clk);
    irq_event <= 0;
  endtask : irq_t
  task automatic end_of_test();
    $display("mismatches %0d n_tests %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 0;
    rd_t(CDZ_ADDR_CTRL, 16'h3040);
    wr_t(4'h5, 16'hFFFF);
    rd_t(4'hF, 16'h0000);
    wr_t(CDZ_ADDR_CTRL, 16'hFFFF);
    rd_t(CDZ_ADDR_CTRL, 16'hFFDF);
    rd_t(CDZ_ADDR_STATUS, 16'h0001);
    chk("doze_active", 16'h0001, {15'h0000, doze_active});
    chk("prescaler", 16'h001F, {11'h000, pll_input_prescaler});
    chk("post_max", 16'h0003, {14'h0000, pll_output_divider});
    nc = 0;
    nf = 0;
    repeat (512)
    begin
      @(negedge clk);
      nc += cpu_tick;
      nf += rc_tick;
    end
    chk("cpu_ticks", 16'h0004, nc);
    chk("rc_ticks", 16'h0002, nf);
    wr_t(CDZ_ADDR_CTRL, 16'h1800);
    rd_t(CDZ_ADDR_CTRL, 16'h7800);
    irq_t();
    rd_t(CDZ_ADDR_CTRL, 16'h7800);
    wr_t(CDZ_ADDR_CTRL, 16'h8800);
    irq_t();
    rd_t(CDZ_ADDR_CTRL, 16'hF000);
    wr_t(CDZ_ADDR_CTRL, 16'h0000);
    wr_t(CDZ_ADDR_CTRL, 16'h0880);
    rd_t(CDZ_ADDR_STATUS, 16'h0000);
    chk("post", 16'h0000, pll_output_divider);
    end_of_test();
  end
endmodule : cdz_clock_divisor_test
